//--- include/logic_and_branch_exec_regs.svh
`ifndef LOGIC_AND_BRANCH_EXEC_REGS_SVH
`define LOGIC_AND_BRANCH_EXEC_REGS_SVH

// Opcode fields, matched against the upper bits of the instruction word
`define OPC_AND_LIT       8'h0B
`define OPC_AND_FILE      6'h05
`define OPC_ADD_CARRY     6'h08
`define OPC_BIT_CLR       4'h9
`define OPC_BRANCH        4'hE

// Condition codes in bits 11:8 of a relative branch
`define COND_CARRY_SET    4'h2
`define COND_CARRY_CLR    4'h3
`define COND_MINUS_SET    4'h6
`define COND_MINUS_CLR    4'h7

// Field positions inside the instruction word
`define FLD_DEST          9
`define FLD_ACCESS        8
`define FLD_BIT_HI        11
`define FLD_BIT_LO        9
`define FLD_SIGN          7

// Access bank layout: low half from bank 0, high half from the top bank
`define ACCESS_SPLIT      8'h80
`define ACCESS_LOW_BANK   4'h0
`define ACCESS_HIGH_BANK  4'hF

// Reset values and program counter step
`define PC_RESET          21'h000000
`define PC_STEP           21'h000002
`define ACC_RESET         8'h00
`define STATUS_RESET      5'h00
`define MEM_ADDR_RESET    12'h000
`define DATA_ZERO         8'h00
`define BIT_ONE           8'h01
`define IR_RESET          16'h0000

// Instruction cycle: time and phases of one core clock each
`define CLK_PERIOD_NS     100
`define INSTR_CYCLE_NS    400
`define PHASES_PER_INSTR  (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)

`endif

//--- include/logic_and_branch_exec_pkg.sv
package logic_and_branch_exec_pkg;

    // Status flags as kept by the core
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } status_flags_t;

    // Data memory request toward the register file
    typedef struct packed {
        logic [11:0] addr;
        logic        we;
        logic [7:0]  wdata;
    } mem_req_t;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_COMPUTE,
        PH_WRITE
    } phase_t;

    // Decoded operation classes
    typedef enum logic [2:0] {
        OP_NONE,
        OP_AND_LIT,
        OP_AND_FILE,
        OP_ADD_CARRY,
        OP_BIT_CLR,
        OP_BRANCH
    } op_t;

endpackage : logic_and_branch_exec_pkg

//--- design/logic_and_branch_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "logic_and_branch_exec_regs.svh"

module logic_and_branch_exec (
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    input  wire logic [15:0]                            instr_word,
    input  wire logic [7:0]                             mem_rdata,
    input  wire logic [3:0]                             bank_pointer,
    output logic [20:0]                                 prog_addr,
    output logic_and_branch_exec_pkg::mem_req_t         mem,
    output logic [7:0]                                  working_accumulator,
    output logic_and_branch_exec_pkg::status_flags_t    status,
    output logic_and_branch_exec_pkg::phase_t           phase,
    output logic                                        nop_cycle
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic_and_branch_exec_pkg::op_t             op;
    logic_and_branch_exec_pkg::op_t             next_op;
    logic_and_branch_exec_pkg::phase_t          next_phase;
    logic_and_branch_exec_pkg::status_flags_t   pend_flags;
    logic_and_branch_exec_pkg::status_flags_t   next_flags;
    logic [15:0]                                ir;
    logic [7:0]                                 result;
    logic [7:0]                                 next_result;
    logic [11:0]                                mem_addr;
    logic                                       mem_we;
    logic [7:0]                                 mem_wdata;

    // Memory request fields gathered into the output struct
    assign mem = '{addr: mem_addr, we: mem_we, wdata: mem_wdata};

    ////////////////////////////////////////////////////////////////////////
    // Decode of the fetched word
    wire logic [15:0] iw          = instr_word;
    wire logic        dec_and_lit = (iw[15:8] == `OPC_AND_LIT);
    wire logic        dec_and_f   = (iw[15:10] == `OPC_AND_FILE);
    wire logic        dec_addc    = (iw[15:10] == `OPC_ADD_CARRY);
    wire logic        dec_bclr    = (iw[15:12] == `OPC_BIT_CLR);
    wire logic        dec_branch  = (iw[15:12] == `OPC_BRANCH) &&
                                    ((iw[11:8] == `COND_CARRY_SET) || (iw[11:8] == `COND_CARRY_CLR) ||
                                     (iw[11:8] == `COND_MINUS_SET) || (iw[11:8] == `COND_MINUS_CLR));

    // Operation class; unknown words execute as no operation
    always_comb begin
        if (dec_and_lit) begin
            next_op = logic_and_branch_exec_pkg::OP_AND_LIT;
        end else if (dec_and_f) begin
            next_op = logic_and_branch_exec_pkg::OP_AND_FILE;
        end else if (dec_addc) begin
            next_op = logic_and_branch_exec_pkg::OP_ADD_CARRY;
        end else if (dec_bclr) begin
            next_op = logic_and_branch_exec_pkg::OP_BIT_CLR;
        end else if (dec_branch) begin
            next_op = logic_and_branch_exec_pkg::OP_BRANCH;
        end else begin
            next_op = logic_and_branch_exec_pkg::OP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand addressing and destination
    wire logic        is_and_lit = (op == logic_and_branch_exec_pkg::OP_AND_LIT);
    wire logic        is_and_f   = (op == logic_and_branch_exec_pkg::OP_AND_FILE);
    wire logic        is_addc    = (op == logic_and_branch_exec_pkg::OP_ADD_CARRY);
    wire logic        is_bclr    = (op == logic_and_branch_exec_pkg::OP_BIT_CLR);
    wire logic        is_branch  = (op == logic_and_branch_exec_pkg::OP_BRANCH);
    wire logic        uses_file  = is_and_f || is_addc || is_bclr;
    wire logic        high_half  = (ir[7:0] >= `ACCESS_SPLIT);
    wire logic [3:0]  access_bk  = high_half ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK;
    wire logic [3:0]  sel_bank   = ir[`FLD_ACCESS] ? bank_pointer : access_bk;
    wire logic [11:0] eff_addr   = {sel_bank, ir[7:0]};
    wire logic        to_file    = is_bclr || ((is_and_f || is_addc) && ir[`FLD_DEST]);
    wire logic        to_acc     = is_and_lit || ((is_and_f || is_addc) && !ir[`FLD_DEST]);

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic and logic
    wire logic [7:0]  operand    = is_and_lit ? ir[7:0] : mem_rdata;
    wire logic [7:0]  and_res    = working_accumulator & operand;
    wire logic [8:0]  add_sum    = {1'b0, working_accumulator} + {1'b0, operand} + {8'h00, status.c};
    wire logic [4:0]  nib_sum    = {1'b0, working_accumulator[3:0]} + {1'b0, operand[3:0]} + {4'h0, status.c};
    wire logic [7:0]  clr_mask   = ~(`BIT_ONE << ir[`FLD_BIT_HI:`FLD_BIT_LO]);
    wire logic        add_ov     = (working_accumulator[7] == operand[7]) &&
                                   (add_sum[7] != working_accumulator[7]);

    // Result and flag set per operation
    always_comb begin
        next_flags  = status;
        next_result = operand;
        if (is_and_lit || is_and_f) begin
            next_result  = and_res;
            next_flags.n = and_res[`FLD_SIGN];
            next_flags.z = (and_res == `DATA_ZERO);
        end else if (is_addc) begin
            next_result   = add_sum[7:0];
            next_flags.n  = add_sum[`FLD_SIGN];
            next_flags.z  = (add_sum[7:0] == `DATA_ZERO);
            next_flags.c  = add_sum[8];
            next_flags.dc = nib_sum[4];
            next_flags.ov = add_ov;
        end else if (is_bclr) begin
            next_result = operand & clr_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Branch condition and target
    logic cond_met;
    always_comb begin
        case (ir[11:8])
            `COND_CARRY_SET: cond_met = status.c;
            `COND_CARRY_CLR: cond_met = !status.c;
            `COND_MINUS_SET: cond_met = status.n;
            `COND_MINUS_CLR: cond_met = !status.n;
            default:         cond_met = 1'b0;
        endcase
    end

    wire logic        take       = is_branch && cond_met;
    wire logic [20:0] br_offset  = {{12{ir[`FLD_SIGN]}}, ir[7:0], 1'b0};
    wire logic [20:0] br_target  = prog_addr + br_offset;

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_comb begin
        case (phase)
            logic_and_branch_exec_pkg::PH_DECODE:  next_phase = logic_and_branch_exec_pkg::PH_READ;
            logic_and_branch_exec_pkg::PH_READ:    next_phase = logic_and_branch_exec_pkg::PH_COMPUTE;
            logic_and_branch_exec_pkg::PH_COMPUTE: next_phase = logic_and_branch_exec_pkg::PH_WRITE;
            default:                               next_phase = logic_and_branch_exec_pkg::PH_DECODE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= logic_and_branch_exec_pkg::PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    // Decode phase: latch word; latch its operation and step the counter unless in a flush cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir <= `IR_RESET;
            op <= logic_and_branch_exec_pkg::OP_NONE;
        end else if (phase == logic_and_branch_exec_pkg::PH_DECODE) begin
            ir <= instr_word;
            op <= nop_cycle ? logic_and_branch_exec_pkg::OP_NONE : next_op;
        end
    end

    // Decode phase preloads the operand address; read phase resolves it for file operations
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_addr <= `MEM_ADDR_RESET;
        end else if (phase == logic_and_branch_exec_pkg::PH_DECODE && !nop_cycle) begin
            mem_addr <= {bank_pointer, instr_word[7:0]};
        end else if (phase == logic_and_branch_exec_pkg::PH_READ && uses_file) begin
            mem_addr <= eff_addr;
        end
    end

    // Compute phase: capture result and flags, raise the write strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result     <= `DATA_ZERO;
            pend_flags <= `STATUS_RESET;
            mem_we     <= 1'b0;
            mem_wdata  <= `DATA_ZERO;
        end else if (phase == logic_and_branch_exec_pkg::PH_COMPUTE) begin
            result     <= next_result;
            pend_flags <= next_flags;
            mem_we     <= to_file;
            mem_wdata  <= next_result;
        end else begin
            mem_we     <= 1'b0;
        end
    end

    // Write phase: accumulator and flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            working_accumulator <= `ACC_RESET;
            status              <= `STATUS_RESET;
        end else if (phase == logic_and_branch_exec_pkg::PH_WRITE) begin
            if (to_acc) begin
                working_accumulator <= result;
            end
            status <= pend_flags;
        end
    end

    // Program counter and flush cycle after a taken branch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_addr <= `PC_RESET;
            nop_cycle <= 1'b0;
        end else if (phase == logic_and_branch_exec_pkg::PH_DECODE && !nop_cycle) begin
            prog_addr <= prog_addr + `PC_STEP;
        end else if (phase == logic_and_branch_exec_pkg::PH_WRITE) begin
            if (take) begin
                prog_addr <= br_target;
            end
            nop_cycle <= take;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_phase_order;
        (phase == logic_and_branch_exec_pkg::PH_WRITE) |=>
            (phase == logic_and_branch_exec_pkg::PH_DECODE) ##1 (phase == logic_and_branch_exec_pkg::PH_READ);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");

    property p_and_lit;
        (phase == logic_and_branch_exec_pkg::PH_COMPUTE && is_and_lit) |=>
            ##1 (working_accumulator == ($past(working_accumulator, 2) & ir[7:0]));
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("literal AND result wrong");

    property p_and_flags;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && (is_and_lit || is_and_f)) |=>
            (status.n == result[7]) && (status.z == (result == `DATA_ZERO)) &&
            (status.c == $past(status.c)) && (status.ov == $past(status.ov)) && (status.dc == $past(status.dc));
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("AND flags wrong");

    property p_dest_file;
        (phase == logic_and_branch_exec_pkg::PH_COMPUTE && (is_and_f || is_addc)) |=>
            (mem.we == ir[`FLD_DEST]) ##1 (ir[`FLD_DEST] || working_accumulator == result);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("destination routing wrong");

    property p_access;
        (phase == logic_and_branch_exec_pkg::PH_READ && uses_file && !ir[`FLD_ACCESS]) |=>
            (mem.addr == {(ir[7] ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK), ir[7:0]});
    endproperty
    a_access: assert property (p_access) else $error("access bank address wrong");

    property p_target;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && take) |=>
            (prog_addr == $past(prog_addr) + {{12{ir[7]}}, ir[7:0], 1'b0});
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    property p_branch_flags;
        (phase == logic_and_branch_exec_pkg::PH_DECODE && dec_branch && !nop_cycle) |=>
            ##3 (status == $past(status, 3)) ##1 (status == $past(status, 4));
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");

    property p_cond_clear;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && is_branch && ir[11:8] == `COND_CARRY_CLR) |=>
            (nop_cycle == !$past(status.c));
    endproperty
    a_cond_clear: assert property (p_cond_clear) else $error("carry clear condition wrong");

    property p_cond_minus;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && is_branch && ir[11:8] == `COND_MINUS_SET) |=>
            (nop_cycle == $past(status.n));
    endproperty
    a_cond_minus: assert property (p_cond_minus) else $error("negative condition wrong");

    property p_flush;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && take) |=>
            nop_cycle [*4] ##1 (!nop_cycle && op == logic_and_branch_exec_pkg::OP_NONE);
    endproperty
    a_flush: assert property (p_flush) else $error("flush cycle wrong");

    property p_no_jump;
        (phase == logic_and_branch_exec_pkg::PH_WRITE && is_branch && !take) |=>
            (prog_addr == $past(prog_addr)) && !nop_cycle;
    endproperty
    a_no_jump: assert property (p_no_jump) else $error("untaken branch moved counter");

    property p_bit_clr;
        (phase == logic_and_branch_exec_pkg::PH_COMPUTE && is_bclr) |=>
            mem.we && (mem.wdata == ($past(mem_rdata) & clr_mask)) ##1 (status == $past(status, 2));
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

    property p_addc;
        (phase == logic_and_branch_exec_pkg::PH_COMPUTE && is_addc) |=>
            ##1 ({status.c, result} == $past(add_sum, 2)) && (status.z == (result == `DATA_ZERO));
    endproperty
    a_addc: assert property (p_addc) else $error("add with carry wrong");

endmodule : logic_and_branch_exec
`default_nettype wire

//--- test/logic_and_branch_exec_bench.sv
`timescale 1ns/1ns
`default_nettype none

module logic_and_branch_exec_bench;

    ////////////////////////////////////////////////////////////////////////////////
    // Design ports and bench state
    logic                                         clk;
    logic                                         nrst;
    logic [15:0]                                  instr_word;
    logic [7:0]                                   mem_rdata;
    logic [3:0]                                   bank_pointer;
    logic [20:0]                                  prog_addr;
    logic_and_branch_exec_pkg::mem_req_t          mem;
    logic [7:0]                                   working_accumulator;
    logic_and_branch_exec_pkg::status_flags_t     status;
    logic_and_branch_exec_pkg::phase_t            phase;
    logic                                         nop_cycle;
    int                                           errors;
    int                                           n_checks;
    logic [7:0]                                   exp_acc;
    logic_and_branch_exec_pkg::status_flags_t     exp_st;
    logic [20:0]                                  start_pc;
    logic [20:0]                                  pc_seen;
    logic [11:0]                                  addr_seen;
    logic                                         we_seen;
    logic                                         flush_seen;
    logic [7:0]                                   wdata_seen;

    logic_and_branch_exec uut (
        .clk                 (clk),
        .nrst                (nrst),
        .instr_word          (instr_word),
        .mem_rdata           (mem_rdata),
        .bank_pointer        (bank_pointer),
        .prog_addr           (prog_addr),
        .mem                 (mem),
        .working_accumulator (working_accumulator),
        .status              (status),
        .phase               (phase),
        .nop_cycle           (nop_cycle)
    );

    // Core clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, count and close
    task check(input logic [31:0] seen, input logic [31:0] expect_v);
        n_checks++;
        if (seen !== expect_v) begin
            errors++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, expect_v);
        end
    endtask : check

    task complete_run;
        $display("Checks made %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    // One instruction cycle, entered in the decode phase one step after a clock edge
    task automatic exec(input logic [15:0] word, input logic [7:0] rd, input logic [3:0] bp);
        start_pc     = prog_addr;
        instr_word   = word;
        mem_rdata    = rd;
        bank_pointer = bp;
        @(posedge clk) #1;
        check(32'(prog_addr), 32'(start_pc + 21'h2));
        check(32'(phase), 32'(logic_and_branch_exec_pkg::PH_READ));
        @(posedge clk) #1;
        addr_seen = mem.addr;
        @(posedge clk) #1;
        we_seen    = mem.we;
        wdata_seen = mem.wdata;
        check(32'(phase), 32'(logic_and_branch_exec_pkg::PH_WRITE));
        @(posedge clk) #1;
        flush_seen = nop_cycle;
        pc_seen    = prog_addr;
        check(32'(mem.we), 32'h0);
        if (flush_seen === 1'b1) begin
            repeat (4) @(posedge clk) #1;
            check(32'(prog_addr), 32'(pc_seen));
            check(32'(nop_cycle), 32'h0);
        end
    endtask : exec

    // Data ops: 0 add with carry, 1 AND register, 2 AND literal, 3 bit clear
    task automatic data_op(input int kind, input logic d, input logic a, input logic [2:0] b,
                           input logic [7:0] f, input logic [3:0] bp, input logic [7:0] rd);
        logic [8:0]                                sum;
        logic [4:0]                                low;
        logic [7:0]                                res;
        logic [15:0]                               word;
        logic                                      to_reg;
        logic_and_branch_exec_pkg::status_flags_t  st;
        st     = exp_st;
        to_reg = d;
        case (kind)
            0: begin
                word  = {6'h08, d, a, f};
                sum   = 9'(exp_acc) + 9'(rd) + 9'(exp_st.c);
                low   = 5'(exp_acc[3:0]) + 5'(rd[3:0]) + 5'(exp_st.c);
                res   = sum[7:0];
                st.c  = sum[8];
                st.dc = low[4];
                st.ov = (exp_acc[7] == rd[7]) && (res[7] != exp_acc[7]);
            end
            1: begin
                word = {6'h05, d, a, f};
                res  = exp_acc & rd;
            end
            2: begin
                word   = {8'h0B, f};
                res    = exp_acc & f;
                to_reg = 1'b0;
            end
            default: begin
                word   = {4'h9, b, a, f};
                res    = rd & ~(8'h01 << b);
                to_reg = 1'b1;
            end
        endcase
        if (kind != 3) begin
            st.n = res[7];
            st.z = (res == 8'h00);
        end
        exec(word, rd, bp);
        if (kind != 2) begin
            check(32'(addr_seen), 32'(a ? {bp, f} : {(f[7] ? 4'hF : 4'h0), f}));
        end
        check(32'(we_seen), 32'(to_reg));
        if (to_reg) begin
            check(32'(wdata_seen), 32'(res));
        end else begin
            exp_acc = res;
        end
        check(32'(working_accumulator), 32'(exp_acc));
        exp_st = st;
        check(32'(status), 32'(exp_st));
        check(32'(flush_seen), 32'h0);
    endtask : data_op

    // Relative branch on a flag, taken or not as the flags stand
    task automatic br(input logic [3:0] cond, input logic [7:0] n);
        logic        t;
        logic [20:0] target;
        case (cond)
            4'h2:    t = exp_st.c;
            4'h3:    t = ~exp_st.c;
            4'h6:    t = exp_st.n;
            default: t = ~exp_st.n;
        endcase
        exec({4'hE, cond, n}, 8'h00, 4'h0);
        target = start_pc + 21'h2 + (t ? {{12{n[7]}}, n, 1'b0} : 21'h0);
        check(32'(pc_seen), 32'(target));
        check(32'(flush_seen), 32'(t));
        check(32'(status), 32'(exp_st));
        check(32'(we_seen), 32'h0);
    endtask : br

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        errors       = 0;
        n_checks     = 0;
        nrst         = 1'b0;
        instr_word   = 16'h0000;
        mem_rdata    = 8'h00;
        bank_pointer = 4'h0;
        exp_acc      = 8'h00;
        exp_st       = '0;
        repeat (6) @(posedge clk);
        #1;
        check(32'(prog_addr), 32'h0);
        check(32'(working_accumulator), 32'h0);
        check(32'(status), 32'h0);
        check(32'(nop_cycle), 32'h0);
        check(32'(phase), 32'(logic_and_branch_exec_pkg::PH_DECODE));
        check(32'(mem), 32'h0);
        nrst = 1'b1;
        data_op(0, 1'b0, 1'b0, 3'h0, 8'h10, 4'h0, 8'hFF);
        data_op(1, 1'b1, 1'b1, 3'h0, 8'h42, 4'h5, 8'hC2);
        br(4'h3, 8'h7F);
        br(4'h2, 8'h05);
        br(4'h6, 8'h80);
        br(4'h7, 8'h10);
        data_op(0, 1'b0, 1'b0, 3'h0, 8'h90, 4'h0, 8'hFF);
        br(4'h2, 8'h05);
        br(4'h3, 8'h05);
        data_op(2, 1'b0, 1'b0, 3'h0, 8'h8F, 4'h0, 8'h00);
        data_op(1, 1'b0, 1'b0, 3'h0, 8'hA0, 4'h7, 8'hC7);
        data_op(2, 1'b0, 1'b0, 3'h0, 8'h70, 4'h0, 8'h00);
        br(4'h7, 8'h03);
        br(4'h6, 8'h03);
        data_op(0, 1'b1, 1'b1, 3'h0, 8'h25, 4'h3, 8'h4C);
        data_op(0, 1'b0, 1'b0, 3'h0, 8'h30, 4'h0, 8'h7F);
        for (int i = 0; i < 8; i++) begin
            data_op(3, 1'b0, i[0], 3'(i), 8'h7C + 8'(i), 4'hA, 8'hC7);
        end
        // Word outside this block's set runs as a plain no operation
        exec(16'hE500, 8'hFF, 4'h0);
        check(32'(we_seen), 32'h0);
        check(32'(flush_seen), 32'h0);
        check(32'(working_accumulator), 32'(exp_acc));
        check(32'(status), 32'(exp_st));
        complete_run();
    end

    // Watchdog at 1000 cycles, well past the expected run of about 120 cycles
    initial begin
        #100000;
        errors++;
        complete_run();
    end

endmodule : logic_and_branch_exec_bench

`default_nettype wire
